// ===== core/uls_line_status_loopback.sv
`include "uls_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module uls_line_status_loopback #(
	parameter int BIT_CLKS   = `ULS_BIT_CLKS,
	parameter int FIFO_DEPTH = `ULS_FIFO_DEPTH
) (
	input  wire logic        clk_i,       // 100 MHz clock
	input  wire logic        rst_i,       // Sync reset, high
	input  wire logic        ce_i,        // Clock enable
	input  wire logic        wb_cyc_i,    // Wishbone cycle
	input  wire logic        wb_stb_i,    // Wishbone strobe
	input  wire logic        wb_we_i,     // Write enable
	input  wire logic [31:0] wb_adr_i,    // Byte address
	input  wire logic [3:0]  wb_sel_i,    // Byte lanes
	input  wire logic [31:0] wb_dat_i,    // Write data
	output logic      [31:0] wb_dat_o,    // Read data
	output logic             wb_ack_o,    // Acknowledge
	input  wire logic        ser_in_i,    // Serial receive line
	output logic             ser_out_o,   // Serial transmit line
	input  wire logic        sir_in_i,    // Infrared receive line
	output logic             sir_out_n_o, // Infrared transmit, low idle
	input  wire logic [3:0]  modem_in_i,  // Modem inputs, active low
	output logic      [3:0]  modem_out_o, // Modem outputs, active low
	output logic             irq_o        // Level interrupt
);
	import uls_pkg::*;
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = AW + 1;
	localparam int BW = $clog2(BIT_CLKS * `ULS_CHAR_BITS + 1);
	localparam logic [BW-1:0] BIT_C  = BW'(BIT_CLKS - 1);
	localparam logic [BW-1:0] HALF_C = BW'(BIT_CLKS / 2 - 1);
	localparam logic [BW-1:0] CHAR_C = BW'(BIT_CLKS * `ULS_CHAR_BITS);
	localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

	// Threshold level for the programmable holding-empty interrupt
	function automatic logic [CW-1:0] fill_level(input logic [1:0] sel);
		unique case (sel)
			2'b00: fill_level = '0;
			2'b01: fill_level = CW'(2);
			2'b10: fill_level = CW'(FIFO_DEPTH / 4);
			2'b11: fill_level = CW'(FIFO_DEPTH / 2);
		endcase
	endfunction

	// ****************************************
	// Registers and bus slave
	// ****************************************
	logic        loop, fifo_en, ptime, sir;
	logic [1:0]  tx_lvl;
	logic [3:0]  mdm_out, mdm_view;
	logic [2:0]  ists, ien;
	logic [7:0]  line_sts;
	logic        req, wr, rd, hit_sts, rd_data, wr_data;
	logic [31:0] next_dat;
	uls_rx_word_t rd_head;

	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr      = req & wb_we_i & wb_sel_i[0];
	assign rd      = req & ~wb_we_i;
	assign hit_sts = rd & (wb_adr_i == `ULS_ADR_LST);
	assign rd_data = rd & (wb_adr_i == `ULS_ADR_DATA);
	assign wr_data = wr & (wb_adr_i == `ULS_ADR_DATA);
	assign mdm_view = loop ? mdm_out : modem_in_i;

	always_comb begin
		next_dat = '0;
		unique case (wb_adr_i)
			`ULS_ADR_DATA: next_dat[9:0] = rd_head;
			`ULS_ADR_MLC:  next_dat[`ULS_MLC_LOOP] = loop;
			`ULS_ADR_LST:  next_dat[7:0] = line_sts;
			`ULS_ADR_CTRL: next_dat[15:0] = {mdm_view, mdm_out, 2'h0, tx_lvl, 1'h0, sir, ptime, fifo_en};
			`ULS_ADR_ISTS: next_dat[2:0] = ists;
			`ULS_ADR_IEN:  next_dat[2:0] = ien;
			default:       next_dat = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? next_dat : 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop    <= `ULS_MLC_RST;
			fifo_en <= 1'b0;
			ptime   <= 1'b0;
			sir     <= 1'b0;
			tx_lvl  <= 2'h0;
			mdm_out <= 4'hf;
			ien     <= 3'h0;
		end else if (ce_i && wr) begin
			if (wb_adr_i == `ULS_ADR_MLC)
				loop <= wb_dat_i[`ULS_MLC_LOOP];
			if (wb_adr_i == `ULS_ADR_CTRL) begin
				fifo_en <= wb_dat_i[`ULS_CTRL_FIFO_EN];
				ptime   <= wb_dat_i[`ULS_CTRL_PTIME];
				sir     <= wb_dat_i[`ULS_CTRL_SIR];
				tx_lvl  <= wb_dat_i[5:4];
				if (wb_sel_i[1])
					mdm_out <= wb_dat_i[11:8];
			end
			if (wb_adr_i == `ULS_ADR_IEN)
				ien <= wb_dat_i[2:0];
		end
	end

	// ****************************************
	// Transmit holding FIFO and shifter
	// ****************************************
	logic [7:0]    tx_mem [FIFO_DEPTH];
	logic [AW-1:0] tx_rp, tx_wp;
	logic [CW-1:0] tx_cnt;
	logic [9:0]    tx_sh;
	logic [3:0]    tx_bits;
	logic [BW-1:0] tx_tmr;
	logic          tx_full, tx_push, tx_pop, tx_busy, tx_line;
	logic          temt, thre, thre_cond, thre_cond_q;

	// Without FIFOs the holding register is a single slot
	assign tx_full = fifo_en ? (tx_cnt == DEPTH_C) : (tx_cnt != '0);
	assign tx_push = wr_data & ~tx_full;
	assign tx_pop  = ~tx_busy & (tx_cnt != '0);
	assign tx_line = tx_busy ? tx_sh[0] : 1'b1;
	assign temt    = (tx_cnt == '0) & ~tx_busy;
	assign thre    = (ptime & fifo_en) ? tx_full : (tx_cnt == '0);
	assign thre_cond = (ptime & fifo_en) ? (tx_cnt <= fill_level(tx_lvl)) : (tx_cnt == '0);

	always_ff @(posedge clk_i) begin
		if (tx_push && ce_i)
			tx_mem[tx_wp] <= wb_dat_i[7:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_rp   <= '0;
			tx_wp   <= '0;
			tx_cnt  <= '0;
			tx_busy <= 1'b0;
			tx_sh   <= 10'h3ff;
			tx_bits <= 4'h0;
			tx_tmr  <= '0;
		end else if (ce_i) begin
			if (tx_push)
				tx_wp <= AW'(tx_wp + 1'b1);
			if (tx_pop)
				tx_rp <= AW'(tx_rp + 1'b1);
			tx_cnt <= CW'(tx_cnt + CW'(tx_push) - CW'(tx_pop));
			if (tx_pop) begin
				tx_busy <= 1'b1;
				tx_sh   <= {1'b1, tx_mem[tx_rp], 1'b0};
				tx_bits <= 4'(`ULS_CHAR_BITS - 1);
				tx_tmr  <= BIT_C;
			end else if (tx_busy) begin
				if (tx_tmr != '0) begin
					tx_tmr <= BW'(tx_tmr - 1'b1);
				end else begin
					tx_tmr  <= BIT_C;
					tx_sh   <= {1'b1, tx_sh[9:1]};
					tx_bits <= 4'(tx_bits - 1'b1);
					if (tx_bits == 4'h0)
						tx_busy <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Line and modem routing
	// ****************************************
	logic rx_line;
	// Loopback is taken before the receiver, so both modes share it
	assign rx_line = loop ? tx_line : (sir ? ~sir_in_i : ser_in_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ser_out_o   <= 1'b1;
			sir_out_n_o <= 1'b0;
			modem_out_o <= 4'hf;
		end else if (ce_i) begin
			ser_out_o   <= (loop | sir) ? 1'b1 : tx_line;
			sir_out_n_o <= (loop | ~sir) ? 1'b0 : ~tx_line;
			modem_out_o <= loop ? 4'hf : mdm_out;
		end
	end

	// ****************************************
	// Receiver with break and framing checks
	// ****************************************
	uls_rx_st_t    rx_st;
	logic [BW-1:0] rx_tmr, low_cnt;
	logic [2:0]    rx_bit;
	logic [7:0]    rx_sh;
	logic          rx_push;
	uls_rx_word_t  rx_word;
	logic          brk_time;

	// Low time counted apart from framing, so break is judged on its own
	assign brk_time = (low_cnt >= CHAR_C);

	always_ff @(posedge clk_i) begin
		if (rst_i)
			low_cnt <= '0;
		else if (ce_i)
			low_cnt <= rx_line ? '0 : (brk_time ? low_cnt : BW'(low_cnt + 1'b1));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_st   <= ULS_RX_IDLE;
			rx_tmr  <= '0;
			rx_bit  <= 3'h0;
			rx_sh   <= 8'h0;
			rx_push <= 1'b0;
			rx_word <= '0;
		end else if (ce_i) begin
			rx_push <= 1'b0;
			if (rx_tmr != '0)
				rx_tmr <= BW'(rx_tmr - 1'b1);
			unique case (rx_st)
				ULS_RX_IDLE: if (!rx_line) begin
					rx_st  <= ULS_RX_START;
					rx_tmr <= HALF_C;
				end
				ULS_RX_START: if (rx_tmr == '0) begin
					rx_st  <= rx_line ? ULS_RX_IDLE : ULS_RX_DATA;
					rx_tmr <= BIT_C;
					rx_bit <= 3'h0;
				end
				ULS_RX_DATA: if (rx_tmr == '0) begin
					rx_sh  <= {rx_line, rx_sh[7:1]};
					rx_tmr <= BIT_C;
					rx_bit <= 3'(rx_bit + 1'b1);
					if (rx_bit == 3'h7)
						rx_st <= ULS_RX_STOP;
				end
				ULS_RX_STOP: if (rx_tmr == '0) begin
					rx_tmr <= BIT_C;
					rx_bit <= 3'h0;
					if (rx_line) begin
						rx_push <= 1'b1;
						rx_word <= {2'b00, rx_sh};
						rx_st   <= ULS_RX_IDLE;
					end else if (rx_sh == 8'h0) begin
						rx_st <= ULS_RX_BRKW;
					end else begin
						rx_push <= 1'b1;
						rx_word <= {2'b01, rx_sh};
						rx_st   <= ULS_RX_DATA;
					end
				end
				ULS_RX_BRKW: if (brk_time) begin
					rx_push <= 1'b1;
					rx_word <= {2'b11, 8'h0};
					rx_st   <= ULS_RX_HOLD;
				end else if (rx_line) begin
					rx_push <= 1'b1;
					rx_word <= {2'b01, 8'h0};
					rx_st   <= ULS_RX_IDLE;
				end
				ULS_RX_HOLD: if (rx_line)
					rx_st <= ULS_RX_IDLE;
				default: rx_st <= ULS_RX_IDLE;
			endcase
		end
	end

	// ****************************************
	// Receive FIFO carrying error flags
	// ****************************************
	uls_rx_word_t  rx_mem [FIFO_DEPTH];
	logic [AW-1:0] rx_rp, rx_wp;
	logic [CW-1:0] rx_cnt, err_cnt;
	logic          rx_full, rx_in, rx_pop, head_seen, head_err, push_err;
	logic          bi_st, fe_st, rfe, bi_v, fe_v, rfe_clr;
	uls_rx_word_t  head;

	assign rx_full  = fifo_en ? (rx_cnt == DEPTH_C) : (rx_cnt != '0);
	assign rx_in    = rx_push & ~rx_full;
	assign rx_pop   = rd_data & (rx_cnt != '0);
	assign head     = rx_mem[rx_rp];
	assign head_err = (rx_cnt != '0) & (head[9] | head[8]);
	assign push_err = rx_in & (rx_word[9] | rx_word[8]);
	// Head flags show once, until the status read that reports them
	assign bi_v = fifo_en ? (rx_cnt != '0) & head[9] & ~head_seen : bi_st;
	assign fe_v = fifo_en ? (rx_cnt != '0) & head[8] & ~head_seen : fe_st;
	assign rfe_clr = hit_sts & ((err_cnt == '0) | (err_cnt == CW'(1) & head_err));
	assign line_sts = {rfe & fifo_en, temt, thre, bi_v, fe_v, 3'h0};
	// Empty buffer reads zero rather than a stale slot
	assign rd_head = (rx_cnt != '0) ? head : '0;

	always_ff @(posedge clk_i) begin
		if (rx_in && ce_i)
			rx_mem[rx_wp] <= rx_word;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_rp   <= '0;
			rx_wp   <= '0;
			rx_cnt  <= '0;
			err_cnt <= '0;
		end else if (ce_i) begin
			if (rx_in)
				rx_wp <= AW'(rx_wp + 1'b1);
			if (rx_pop)
				rx_rp <= AW'(rx_rp + 1'b1);
			rx_cnt  <= CW'(rx_cnt + CW'(rx_in) - CW'(rx_pop));
			err_cnt <= CW'(err_cnt + CW'(push_err) - CW'(rx_pop & head_err));
		end
	end

	// Set wins over the clearing read in bi_st, fe_st and rfe below
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_seen <= 1'b0;
			bi_st     <= 1'b0;
			fe_st     <= 1'b0;
			rfe       <= 1'b0;
		end else if (ce_i) begin
			if (rx_pop)
				head_seen <= 1'b0;
			else if (hit_sts)
				head_seen <= 1'b1;
			bi_st <= (rx_in & rx_word[9]) | (bi_st & ~hit_sts);
			fe_st <= (rx_in & rx_word[8]) | (fe_st & ~hit_sts);
			rfe   <= (fifo_en & push_err) | (rfe & ~rfe_clr);
		end
	end

	// ****************************************
	// Interrupt status, clear and enable
	// ****************************************
	logic [2:0] evt, clr;
	assign clr = (wr && wb_adr_i == `ULS_ADR_ICLR) ? wb_dat_i[2:0] : 3'h0;
	// Events ignore the loopback bit so every source keeps working
	assign evt = {push_err, rx_in, thre_cond & ~thre_cond_q};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			thre_cond_q <= 1'b1;
			ists        <= 3'h0;
			irq_o       <= 1'b0;
		end else if (ce_i) begin
			thre_cond_q <= thre_cond;
			ists        <= evt | (ists & ~clr);
			irq_o       <= |(ists & ien);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	a_loop_out_high: assert property (loop && !sir |=> ser_out_o)
		else $error("serial output not held high in loopback");
	a_sir_loop_low: assert property (loop && sir |=> !sir_out_n_o)
		else $error("infrared output not held low in loopback");
	a_modem_loop: assert property (loop |-> mdm_view == mdm_out)
		else $error("modem inputs not fed from outputs in loopback");
	a_temt_idle: assert property (temt |-> tx_line && tx_cnt == '0)
		else $error("transmitter empty while data pending");
	a_thre_irq: assert property (evt[0] && ien[0] ##1 ce_i |=> irq_o)
		else $error("holding empty interrupt missing");
	a_brk_frame: assert property (rx_push && rx_word[9] |-> rx_word[8] && rx_word[7:0] == 8'h0)
		else $error("break character without framing error");
	a_brk_once: assert property (rx_push && rx_word[9] |=> !rx_push [*2])
		else $error("more than one character for a break");
	a_bi_clear: assert property (!fifo_en && hit_sts && !rx_in ##1 !fifo_en |-> !bi_v)
		else $error("break flag not cleared by status read");
	a_rfe_set: assert property (fifo_en && push_err |=> rfe)
		else $error("fifo error flag not set");

	c_break: cover property (rx_push && rx_word[9]);
	c_loop_char: cover property (loop && rx_push);
	c_rfe_clear: cover property (rfe ##1 !rfe);
endmodule
`default_nettype wire

// ===== core/uls_pkg.sv
package uls_pkg;
	typedef enum logic [2:0] {
		ULS_RX_IDLE  = 3'b000,
		ULS_RX_START = 3'b001,
		ULS_RX_DATA  = 3'b010,
		ULS_RX_STOP  = 3'b011,
		ULS_RX_BRKW  = 3'b100,
		ULS_RX_HOLD  = 3'b101
	} uls_rx_st_t;
	typedef logic [9:0] uls_rx_word_t;
endpackage

// ===== core/uls_regs.svh
`ifndef ULS_REGS_SVH
`define ULS_REGS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ULS_ADR_DATA       32'h5000_1100
`define ULS_ADR_MLC        32'h5000_1110
`define ULS_ADR_LST        32'h5000_1114
`define ULS_ADR_CTRL       32'h5000_1120
`define ULS_ADR_ISTS       32'h5000_1124
`define ULS_ADR_ICLR       32'h5000_1128
`define ULS_ADR_IEN        32'h5000_112c
// ****************************************
// Field positions
// ****************************************
`define ULS_MLC_LOOP       4
`define ULS_LST_RFE        7
`define ULS_LST_TEMT       6
`define ULS_LST_THRE       5
`define ULS_LST_BI         4
`define ULS_LST_FE         3
`define ULS_CTRL_FIFO_EN   0
`define ULS_CTRL_PTIME     1
`define ULS_CTRL_SIR       2
`define ULS_INT_THRE       0
`define ULS_INT_RXD        1
`define ULS_INT_LERR       2
// ****************************************
// Reset values and timing
// ****************************************
`define ULS_MLC_RST        1'h0
`define ULS_CLK_HZ         100000000
`define ULS_BAUD           115200
`define ULS_BIT_CLKS       (`ULS_CLK_HZ / `ULS_BAUD)
`define ULS_CHAR_BITS      10
`define ULS_FIFO_DEPTH     16
`endif

// ===== testbench/uls_line_status_loopback_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uls_regs.svh"
module uls_line_status_loopback_tb_top;
	localparam int BITC = 8;
	localparam int CHAR = 12 * BITC;
	logic        clk_i     = 1'b0;
	logic        rst_i     = 1'b1;
	logic        cyc       = 1'b0;
	logic        stb       = 1'b0;
	logic        we        = 1'b0;
	logic [31:0] adr       = 32'h0;
	logic [31:0] wdat      = 32'h0;
	logic [3:0]  sel       = 4'h0;
	logic [3:0]  modem_in  = 4'ha;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        ser_out_o;
	logic        sir_out_n_o;
	logic [3:0]  modem_out_o;
	logic        irq_o;
	logic        ser_line;
	logic        sir_line;
	int          n_fail    = 0;
	int          n_tests   = 0;
	always #5 clk_i = ~clk_i;
	uls_line_status_loopback #(.BIT_CLKS(BITC), .FIFO_DEPTH(16)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ser_in_i(ser_line), .ser_out_o(ser_out_o), .sir_in_i(sir_line),
		.sir_out_n_o(sir_out_n_o), .modem_in_i(modem_in), .modem_out_o(modem_out_o),
		.irq_o(irq_o));
	uls_peer #(.BIT_CLKS(BITC)) PEER (.clk_i(clk_i), .ser_o(ser_line), .sir_o(sir_line));
	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk("bus ack", 32'h1, 32'h0);
		rd = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		wb(1'b1, a, d, v);
	endtask
	task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] m,
			input logic [31:0] exp);
		logic [31:0] v;
		wb(1'b0, a, 32'h0, v);
		chk(what, exp, v & m);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rdc("status at reset", `ULS_ADR_LST, 32'hffff_ffff, 32'h60);
		rdc("loop ctrl at reset", `ULS_ADR_MLC, 32'hffff_ffff, 32'h0);
		wr(`ULS_ADR_MLC, 32'hffff_ffef);
		rdc("loop ctrl reserved", `ULS_ADR_MLC, 32'hffff_ffff, 32'h0);
		wr(`ULS_ADR_LST, 32'hffff_ffff);
		rdc("status read only", `ULS_ADR_LST, 32'hffff_ffff, 32'h60);
		rdc("unmapped", 32'h5000_1200, 32'hffff_ffff, 32'h0);
	endtask
	task automatic t_loop(input logic ir, input logic [7:0] d);
		logic bad;
		bad = 1'b0;
		wr(`ULS_ADR_CTRL, 32'h500 | {29'h0, ir, 2'h0});
		wr(`ULS_ADR_MLC, 32'h10);
		rdc("loop ctrl", `ULS_ADR_MLC, 32'hffff_ffff, 32'h10);
		rdc("modem view", `ULS_ADR_CTRL, 32'hf000, 32'h5000);
		chk("modem outs", 32'hf, {28'h0, modem_out_o});
		wr(`ULS_ADR_ICLR, 32'h7);
		wr(`ULS_ADR_IEN, 32'h2);
		wr(`ULS_ADR_DATA, {24'h0, d});
		repeat (CHAR) begin
			@(posedge clk_i);
			bad = bad | (ir ? sir_out_n_o : ~ser_out_o);
		end
		chk("outer line idle", 32'h0, {31'h0, bad});
		chk("irq in loopback", 32'h1, {31'h0, irq_o});
		rdc("looped char", `ULS_ADR_DATA, 32'h3ff, {24'h0, d});
		wr(`ULS_ADR_IEN, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(`ULS_ADR_ICLR, 32'h2);
		wr(`ULS_ADR_IEN, 32'h2);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wr(`ULS_ADR_IEN, 32'h0);
		wr(`ULS_ADR_MLC, 32'h0);
		repeat (2) @(posedge clk_i);
		chk("modem outs normal", 32'h5, {28'h0, modem_out_o});
	endtask
	task automatic t_tx();
		wr(`ULS_ADR_CTRL, 32'hf00);
		wr(`ULS_ADR_ICLR, 32'h7);
		wr(`ULS_ADR_IEN, 32'h1);
		wr(`ULS_ADR_DATA, 32'h3c);
		rdc("tx busy", `ULS_ADR_LST, 32'h40, 32'h0);
		repeat (CHAR) @(posedge clk_i);
		rdc("tx drained", `ULS_ADR_LST, 32'hff, 32'h60);
		chk("holding empty irq", 32'h1, {31'h0, irq_o});
		wr(`ULS_ADR_IEN, 32'h0);
	endtask
	task automatic t_brk();
		PEER.brk(12);
		repeat (2 * BITC) @(posedge clk_i);
		rdc("break status", `ULS_ADR_LST, 32'hff, 32'h78);
		rdc("break cleared", `ULS_ADR_LST, 32'hff, 32'h60);
		rdc("break char", `ULS_ADR_DATA, 32'h3ff, 32'h300);
	endtask
	task automatic t_fe();
		wr(`ULS_ADR_CTRL, 32'hf01);
		PEER.send(8'h12, 1'b1);
		PEER.send(8'h55, 1'b0);
		repeat (CHAR) @(posedge clk_i);
		rdc("error queued", `ULS_ADR_LST, 32'hff, 32'he0);
		rdc("error kept", `ULS_ADR_LST, 32'hff, 32'he0);
		rdc("good char", `ULS_ADR_DATA, 32'h3ff, 32'h012);
		rdc("error at head", `ULS_ADR_LST, 32'hff, 32'he8);
		rdc("error read off", `ULS_ADR_LST, 32'hff, 32'h60);
		rdc("framed char", `ULS_ADR_DATA, 32'h3ff, 32'h155);
		rdc("resync char", `ULS_ADR_DATA, 32'h3ff, 32'h0ff);
	endtask
	task automatic t_ir_brk();
		wr(`ULS_ADR_CTRL, 32'hf05);
		PEER.send(8'h3c, 1'b1);
		PEER.brk(12);
		repeat (2 * BITC) @(posedge clk_i);
		rdc("break behind", `ULS_ADR_LST, 32'hff, 32'he0);
		rdc("ir char", `ULS_ADR_DATA, 32'h3ff, 32'h03c);
		rdc("ir break head", `ULS_ADR_LST, 32'hff, 32'hf8);
		rdc("ir break char", `ULS_ADR_DATA, 32'h3ff, 32'h300);
	endtask
	task automatic t_prog();
		wr(`ULS_ADR_CTRL, 32'hf03);
		for (int i = 0; i < 17; i++) wr(`ULS_ADR_DATA, i);
		rdc("fifo full", `ULS_ADR_LST, 32'h60, 32'h20);
		wr(`ULS_ADR_ICLR, 32'h7);
		rdc("no early event", `ULS_ADR_ISTS, 32'h1, 32'h0);
		repeat (18 * 10 * BITC) @(posedge clk_i);
		rdc("fifo drained", `ULS_ADR_LST, 32'h60, 32'h40);
		rdc("threshold event", `ULS_ADR_ISTS, 32'h1, 32'h1);
	endtask
	// ****************************************
	// Sequence, watchdog and verdict
	// ****************************************
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_loop(1'b0, 8'ha5);
		t_loop(1'b1, 8'h5a);
		t_tx();
		t_brk();
		t_fe();
		t_ir_brk();
		t_prog();
		complete_run();
	end
	// Tests need about 2600 cycles; over seven times that is a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		complete_run();
	end
endmodule
`default_nettype wire

// ===== testbench/uls_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Remote serial peer on the receive side
// ****************************************
module uls_peer #(
	parameter int BIT_CLKS = 8
) (
	input  wire logic clk_i, // Bench clock
	output logic      ser_o, // Serial line, idle high
	output logic      sir_o  // Infrared line, pulse high
);
	initial begin
		ser_o = 1'b1;
		sir_o = 1'b0;
	end
	// Both lines carry the same level, infrared inverted
	task automatic hold(input logic v, input int bits);
		repeat (bits * BIT_CLKS) begin
			@(posedge clk_i);
			ser_o <= v;
			sir_o <= ~v;
		end
	endtask
	// Stop level selectable so a framing fault can be injected
	task automatic send(input logic [7:0] d, input logic stop_ok);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(d[i], 1);
		hold(stop_ok, 1);
		hold(1'b1, 2);
	endtask
	task automatic brk(input int bits);
		hold(1'b0, bits);
		hold(1'b1, 2);
	endtask
endmodule
`default_nettype wire
